/* core/ipc_map.svh */
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH

// Register indices on the two-wire control interface.
`define IPC_IDX_PWR2        7'h02
`define IPC_IDX_PAIR1       7'h16
`define IPC_IDX_PAIR2       7'h17

// Field positions.
`define IPC_BIT_AMP_1A      7
`define IPC_BIT_AMP_1B      6
`define IPC_BIT_AMP_2A      5
`define IPC_BIT_AMP_2B      4
`define IPC_BIT_DIFF        1

// Reset values of the stored fields.
`define IPC_RST_AMP         1'b0
`define IPC_RST_DIFF        1'b1

// Default 7-bit device address; the value is arbitrary.
`define IPC_DEV_ADDR        7'h1A

// Bit count of one byte on the wire.
`define IPC_BYTE_BITS       4'h8

`endif

/* core/ipc_pkg.sv */
package ipc_pkg;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_DEV     = 4'b0001,
		ST_DEV_ACK = 4'b0010,
		ST_IDX     = 4'b0011,
		ST_IDX_ACK = 4'b0100,
		ST_LOW     = 4'b0101,
		ST_LOW_ACK = 4'b0110,
		ST_TX      = 4'b0111,
		ST_TX_ACK  = 4'b1000
	} ipc_state_t;

	typedef struct packed {
		logic amp_1a_on;
		logic amp_1b_on;
		logic amp_2a_on;
		logic amp_2b_on;
	} ipc_amp_t;

	typedef struct packed {
		logic pos_to_a;
		logic neg_to_a;
		logic neg_to_b;
	} ipc_route_t;

endpackage

/* core/ipc_input_path_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ipc_map.svh"

module ipc_input_path_regs #(
	parameter logic [6:0] DEV_ADDR = `IPC_DEV_ADDR
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          srst,
	// Two-wire control interface
	input  wire logic          scl_in,
	input  wire logic          sda_in,
	output logic               sda_out,
	output logic               sda_oe,
	// Clamp release requests per pair, bypass pair last
	input  wire logic [2:0]    clamp_release,
	// Amplifier, routing and clamp controls
	output ipc_pkg::ipc_amp_t  amp_on,
	output ipc_pkg::ipc_route_t pair1_route,
	output ipc_pkg::ipc_route_t pair2_route,
	output logic               pair1_differential_select,
	output logic               pair2_differential_select,
	output logic               bypass_to_speaker,
	output logic [2:0]         pin_clamp_on
);

	ipc_pkg::ipc_state_t state_r;
	logic                scl_q_r;
	logic                sda_q_r;
	logic [3:0]          cnt_r;
	logic [7:0]          shift_r;
	logic [7:0]          tx_r;
	logic                rw_r;
	logic                hi_r;
	logic                ack_ok_r;
	logic [6:0]          idx_r;
	logic                d8_r;
	logic                amp_1a_r;
	logic                amp_1b_r;
	logic                amp_2a_r;
	logic                amp_2b_r;
	logic                diff1_r;
	logic                diff2_r;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_cond;
	logic                stop_cond;
	logic                wr_en;
	logic [8:0]          wr_data;
	logic [8:0]          rd_data;

	// Returns the 9-bit read-back word of the register at an index.
	function automatic logic [8:0] reg_read(
		input logic [6:0] idx,
		input logic       a1a,
		input logic       a1b,
		input logic       a2a,
		input logic       a2b,
		input logic       d1,
		input logic       d2
	);
		logic [8:0] v;
		v = 9'h000;
		if (idx == `IPC_IDX_PWR2)
		begin
			v[`IPC_BIT_AMP_1A] = a1a;
			v[`IPC_BIT_AMP_1B] = a1b;
			v[`IPC_BIT_AMP_2A] = a2a;
			v[`IPC_BIT_AMP_2B] = a2b;
		end
		else if (idx == `IPC_IDX_PAIR1)
		begin
			v[`IPC_BIT_DIFF] = d1;
		end
		else if (idx == `IPC_IDX_PAIR2)
		begin
			v[`IPC_BIT_DIFF] = d2;
		end
		return v;
	endfunction

	assign scl_rise   = scl_in & ~scl_q_r;
	assign scl_fall   = ~scl_in & scl_q_r;
	assign start_cond = scl_in & scl_q_r & sda_q_r & ~sda_in;
	assign stop_cond  = scl_in & scl_q_r & ~sda_q_r & sda_in;
	assign wr_en      = (state_r == ipc_pkg::ST_LOW) && scl_fall && (cnt_r == `IPC_BYTE_BITS);
	assign wr_data    = {d8_r, shift_r};
	assign rd_data    = reg_read(idx_r, amp_1a_r, amp_1b_r, amp_2a_r, amp_2b_r,
	                             diff1_r, diff2_r);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end
		else
		begin
			scl_q_r <= scl_in;
			sda_q_r <= sda_in;
		end
	end

	// Serial protocol: device address, index byte with data bit 8, low data byte.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_r  <= ipc_pkg::ST_IDLE;
			cnt_r    <= 4'h0;
			shift_r  <= 8'h00;
			tx_r     <= 8'h00;
			rw_r     <= 1'b0;
			hi_r     <= 1'b0;
			ack_ok_r <= 1'b0;
			idx_r    <= 7'h00;
			d8_r     <= 1'b0;
		end
		else if (start_cond)
		begin
			state_r <= ipc_pkg::ST_DEV;
			cnt_r   <= 4'h0;
		end
		else if (stop_cond)
		begin
			state_r <= ipc_pkg::ST_IDLE;
		end
		else
		begin
			case (state_r)
				ipc_pkg::ST_DEV, ipc_pkg::ST_IDX, ipc_pkg::ST_LOW:
				begin
					if (scl_rise && cnt_r != `IPC_BYTE_BITS)
					begin
						shift_r <= {shift_r[6:0], sda_in};
						cnt_r   <= cnt_r + 4'h1;
					end
					else if (scl_fall && cnt_r == `IPC_BYTE_BITS)
					begin
						cnt_r <= 4'h0;
						if (state_r == ipc_pkg::ST_DEV)
						begin
							rw_r    <= shift_r[0];
							state_r <= (shift_r[7:1] == DEV_ADDR) ? ipc_pkg::ST_DEV_ACK
							                                     : ipc_pkg::ST_IDLE;
						end
						else if (state_r == ipc_pkg::ST_IDX)
						begin
							idx_r   <= shift_r[7:1];
							d8_r    <= shift_r[0];
							state_r <= ipc_pkg::ST_IDX_ACK;
						end
						else
						begin
							state_r <= ipc_pkg::ST_LOW_ACK;
						end
					end
				end
				ipc_pkg::ST_DEV_ACK:
				begin
					if (scl_fall)
					begin
						if (rw_r)
						begin
							tx_r    <= {7'h00, rd_data[8]};
							hi_r    <= 1'b1;
							state_r <= ipc_pkg::ST_TX;
						end
						else
						begin
							state_r <= ipc_pkg::ST_IDX;
						end
					end
				end
				ipc_pkg::ST_IDX_ACK, ipc_pkg::ST_LOW_ACK:
				begin
					if (scl_fall)
					begin
						state_r <= (state_r == ipc_pkg::ST_IDX_ACK) ? ipc_pkg::ST_LOW
						                                           : ipc_pkg::ST_IDLE;
					end
				end
				ipc_pkg::ST_TX:
				begin
					if (scl_fall)
					begin
						cnt_r <= cnt_r + 4'h1;
						tx_r  <= {tx_r[6:0], 1'b0};
						if (cnt_r == 4'h7)
						begin
							cnt_r   <= 4'h0;
							state_r <= ipc_pkg::ST_TX_ACK;
						end
					end
				end
				ipc_pkg::ST_TX_ACK:
				begin
					if (scl_rise)
					begin
						ack_ok_r <= ~sda_in;
					end
					else if (scl_fall)
					begin
						hi_r <= 1'b0;
						if (ack_ok_r && hi_r)
						begin
							tx_r    <= rd_data[7:0];
							state_r <= ipc_pkg::ST_TX;
						end
						else
						begin
							state_r <= ipc_pkg::ST_IDLE;
						end
					end
				end
				default:
				begin
					state_r <= ipc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_comb
	begin
		sda_out = 1'b0;
		case (state_r)
			ipc_pkg::ST_DEV_ACK, ipc_pkg::ST_IDX_ACK, ipc_pkg::ST_LOW_ACK:
				sda_oe = 1'b1;
			ipc_pkg::ST_TX:
				sda_oe = ~tx_r[7];
			default:
				sda_oe = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			amp_1a_r <= `IPC_RST_AMP;
			amp_1b_r <= `IPC_RST_AMP;
			amp_2a_r <= `IPC_RST_AMP;
			amp_2b_r <= `IPC_RST_AMP;
		end
		else if (wr_en && idx_r == `IPC_IDX_PWR2)
		begin
			amp_1a_r <= wr_data[`IPC_BIT_AMP_1A];
			amp_1b_r <= wr_data[`IPC_BIT_AMP_1B];
			amp_2a_r <= wr_data[`IPC_BIT_AMP_2A];
			amp_2b_r <= wr_data[`IPC_BIT_AMP_2B];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			diff1_r <= `IPC_RST_DIFF;
			diff2_r <= `IPC_RST_DIFF;
		end
		else if (wr_en && idx_r == `IPC_IDX_PAIR1)
			diff1_r <= wr_data[`IPC_BIT_DIFF];
		else if (wr_en && idx_r == `IPC_IDX_PAIR2)
			diff2_r <= wr_data[`IPC_BIT_DIFF];
	end

	assign amp_on = '{amp_1a_on: amp_1a_r, amp_1b_on: amp_1b_r,
	                  amp_2a_on: amp_2a_r, amp_2b_on: amp_2b_r};
	assign pair1_differential_select = diff1_r;
	assign pair2_differential_select = diff2_r;
	assign pair1_route = '{pos_to_a: 1'b1, neg_to_a: diff1_r, neg_to_b: ~diff1_r};
	assign pair2_route = '{pos_to_a: 1'b1, neg_to_a: diff2_r, neg_to_b: ~diff2_r};
	assign bypass_to_speaker = 1'b1;
	assign pin_clamp_on = srst ? 3'h7 : ~clamp_release;

endmodule
`default_nettype wire

/* sim/ipc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_chk (
	input wire logic                clk,
	input wire logic                srst,
	input wire logic                sda_oe,
	input wire logic [2:0]          clamp_release,
	input wire ipc_pkg::ipc_amp_t   amp_on,
	input wire ipc_pkg::ipc_route_t pair1_route,
	input wire ipc_pkg::ipc_route_t pair2_route,
	input wire logic                pair1_differential_select,
	input wire logic                pair2_differential_select,
	input wire logic                bypass_to_speaker,
	input wire logic [2:0]          pin_clamp_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_rst_amp; $fell(srst) |-> amp_on == 4'h0; endproperty
	a_rst_amp: assert property (p_rst_amp) else $error("amp reset");
	property p_rst_diff;
		$fell(srst) |-> pair1_differential_select && pair2_differential_select;
	endproperty
	a_rst_diff: assert property (p_rst_diff) else $error("diff reset");
	property p_rt1; pair1_route == {1'b1, pair1_differential_select,
		!pair1_differential_select}; endproperty
	a_rt1: assert property (p_rt1) else $error("pair1 route");
	property p_rt2; pair2_route == {1'b1, pair2_differential_select,
		!pair2_differential_select}; endproperty
	a_rt2: assert property (p_rt2) else $error("pair2 route");
	property p_byp; bypass_to_speaker == 1'b1; endproperty
	a_byp: assert property (p_byp) else $error("bypass");
	property p_clamp; pin_clamp_on == ~clamp_release; endproperty
	a_clamp: assert property (p_clamp) else $error("clamp");
	property p_amp_chg; !$stable(amp_on) |-> sda_oe; endproperty
	a_amp_chg: assert property (p_amp_chg) else $error("amp change");
	property p_diff_chg;
		!$stable({pair1_differential_select, pair2_differential_select}) |-> sda_oe;
	endproperty
	a_diff_chg: assert property (p_diff_chg) else $error("diff change");
	property p_oe_len; $rose(sda_oe) |-> sda_oe [*4]; endproperty
	a_oe_len: assert property (p_oe_len) else $error("ack length");
endmodule
bind ipc_input_path_regs ipc_chk ipc_chk_i (.clk, .srst, .sda_oe, .clamp_release, .amp_on,
	.pair1_route, .pair2_route, .pair1_differential_select, .pair2_differential_select,
	.bypass_to_speaker, .pin_clamp_on);
`default_nettype wire

/* sim/ipc_input_path_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module ipc_input_path_regs_tb_top;
	logic               clk, srst, scl_in, sda_m, sda_out, sda_oe, d1, d2, byp;
	wire logic          sda_in;
	logic [2:0]         cr, pc;
	ipc_pkg::ipc_amp_t  amp_on;
	ipc_pkg::ipc_route_t r1, r2;
	int                 fail_count, check_count;
	logic               a;
	logic [15:0]        q;
	// The open-drain wire is low when either side pulls it.
	assign sda_in = sda_m & ~sda_oe;
	ipc_input_path_regs ipc_input_path_regs_i (.clk, .srst, .scl_in, .sda_in, .sda_out,
		.sda_oe, .clamp_release(cr), .amp_on, .pair1_route(r1), .pair2_route(r2),
		.pair1_differential_select(d1), .pair2_differential_select(d2),
		.bypass_to_speaker(byp), .pin_clamp_on(pc));
	task h; repeat (3) @(negedge clk); endtask
	task bt(input logic b, output logic s);
		h; sda_m = b; h; scl_in = 1; h; s = sda_in; scl_in = 0;
	endtask
	task wb(input logic [7:0] v, output logic k);
		logic s;
		for (int i = 7; i >= 0; i--) bt(v[i], s);
		bt(1'b1, s); k = ~s;
	endtask
	task rb(input logic n, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) bt(1'b1, v[i]);
		bt(n, s);
	endtask
	task st; h; sda_m = 1; h; scl_in = 1; h; sda_m = 0; h; scl_in = 0; endtask
	task sp; h; sda_m = 0; h; scl_in = 1; h; sda_m = 1; h; endtask
	task wr(input logic [6:0] x, input logic [8:0] d, output logic k);
		logic k1, k2, k3;
		st; wb(8'h34, k1); wb({x, d[8]}, k2); wb(d[7:0], k3); sp; k = k1 & k2 & k3;
	endtask
	task rd(input logic [6:0] x, output logic [15:0] d);
		logic k;
		st; wb(8'h34, k); wb({x, 1'b0}, k); st; wb(8'h35, k);
		rb(1'b0, d[15:8]); rb(1'b1, d[7:0]); sp;
	endtask
	task t_reset;
		`CHK("amp", 4'h0, amp_on)
		`CHK("diff", 2'h3, {d1, d2})
		`CHK("route", 6'h36, {r1, r2})
		`CHK("byp", 1'b1, byp)
		`CHK("sda_out", 1'b0, sda_out)
		rd(7'h02, q); `CHK("rd02", 16'h0000, q)
		rd(7'h16, q); `CHK("rd16", 16'h0002, q)
		rd(7'h17, q); `CHK("rd17", 16'h0002, q)
	endtask
	task t_amp;
		for (int i = 0; i < 4; i++)
		begin
			wr(7'h02, 9'h10F | (9'h080 >> i), a); `CHK("ack", 1'b1, a)
			`CHK("amp", 4'h8 >> i, amp_on)
			rd(7'h02, q); `CHK("rd02", 16'h0080 >> i, q)
		end
	endtask
	task t_mode;
		for (int p = 0; p < 2; p++)
		begin
			wr(p ? 7'h17 : 7'h16, 9'h1FD, a);
			`CHK("diff", p ? 2'h2 : 2'h1, {d1, d2})
			`CHK("route", p ? 6'h35 : 6'h2E, {r1, r2})
			rd(p ? 7'h17 : 7'h16, q); `CHK("rdm", 16'h0000, q)
			wr(p ? 7'h17 : 7'h16, 9'h002, a); `CHK("diff", 2'h3, {d1, d2})
		end
	endtask
	task t_refuse;
		wr(7'h30, 9'h1FF, a); `CHK("amp", 4'h1, amp_on)
		rd(7'h30, q); `CHK("rd30", 16'h0000, q)
		st; wb(8'h20, a); sp; `CHK("nack", 1'b0, a)
	endtask
	task t_use;
		wr(7'h16, 9'h000, a); `CHK("ack", 1'b1, a)
		wr(7'h02, 9'h0E0, a); `CHK("amp", 4'hE, amp_on)
		`CHK("route", 6'h2E, {r1, r2})
		cr = 3'h3; @(negedge clk); `CHK("clamp", 3'h4, pc)
	endtask
	task t_clamp;
		for (int v = 0; v < 8; v++)
		begin
			cr = v[2:0]; @(negedge clk); `CHK("clamp", ~v[2:0], pc)
		end
		srst = 1; repeat (2) @(negedge clk);
		`CHK("clamp_rst", 3'h7, pc)
		`CHK("amp_rst", 4'h0, amp_on)
		`CHK("diff_rst", 2'h3, {d1, d2})
		srst = 0; repeat (2) @(negedge clk);
		rd(7'h16, q); `CHK("rd16_rst", 16'h0002, q)
	endtask
	task tally_and_finish;
		if (fail_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		#400000; fail_count++; tally_and_finish;
	end
	initial
	begin
		srst = 1; scl_in = 1; sda_m = 1; cr = 3'h0; fail_count = 0; check_count = 0;
		repeat (20) @(negedge clk);
		srst = 0; repeat (2) @(negedge clk);
		t_reset; t_amp; t_mode; t_refuse; t_use; t_clamp;
		tally_and_finish;
	end
endmodule
`default_nettype wire
